/* vpic_defs.vh */
// Constants for the vectored priority interrupt controller
// Behaviour
// (R1) Hardware sets request flag; software clears it
// (R2) Only enabled flagged sources join arbitration
// (R3) Each source has 3-bit priority field
// (R4) Latch 7-bit vector and 4-bit level
// (R5) Latched level equals winner's programmed priority
// (R6) Fields packed in request-number order
// (R7) Request 0 is vector 8, then sequential
// (R8) CPU priority field at status bits 7:5
// (R9) Fourth priority bit read-only to software
// (R10) Full level is top bit over field
// (R11) Block user interrupts at top bit or 7
// (R12) Nesting disable makes priority field read-only
// (R13) Control one nesting/traps; two edges/alt table
// (R14) Seventeen software-visible controller registers; the code decodes twenty
// (R15) Alt select redirects vector fetches
// (R16) Nesting disable stops preemption of service
// (R17) Polarity bit: 1 falling, 0 rising edge
// (R18) Highest priority above level; low number ties
`ifndef VPIC_DEFS_VH
`define VPIC_DEFS_VH
// ====================================================
// Register indices (word addresses)
`define A_CTRL_ONE 5'h00
`define A_CTRL_TWO 5'h01
`define A_FLAG0 5'h02
`define A_EN0 5'h04
`define A_PRI0 5'h06
`define A_PENDING 5'h10
`define A_STATUS 5'h11
`define A_CORE 5'h12
`define A_IRQ_STAT 5'h13
`define A_IRQ_MASK 5'h14
`define A_SERVICE 5'h15
// ====================================================
// Fields
`define B_NEST_DIS 15
`define B_ALT_TABLE 15
`define B_TOP_LEVEL 3
`define F_CPU_PRI_HI 7
`define F_CPU_PRI_LO 5
`define FIRST_VECTOR 7'h08
`define PRI_RESET 3'h4
`define LEVEL_BLOCK 3'h7
`define BITS_PER_WORD 16
`define PRI_PER_WORD 4
`define PRI_STRIDE 4
`endif

/* vpic_ctrl.v */
// Vectored priority interrupt controller with register port
`include "vpic_defs.vh"
module vpic_ctrl #(
  parameter N_SRC = 32,
  parameter N_EXT = 3
) (
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire [N_SRC-1:0] periph_req,
  input wire [N_EXT-1:0] ext_pin,
  input wire trap_active,
  input wire irq_ack,
  input wire irq_return,
  output reg irq_pending,
  output reg [6:0] pending_vector_number,
  output reg [3:0] pending_new_level,
  output reg alt_table_select,
  output wire irq
);
  // ====================================================
  // State
  reg [15:0] int_ctrl_one_r;
  reg [N_EXT-1:0] ext_pol_r;
  reg [N_SRC-1:0] flag_r, en_r;
  reg [2:0] pri_r [0:N_SRC-1];
  reg [2:0] cpu_priority_field_r;
  reg cpu_priority_top_bit_r;
  reg in_service_r;
  reg [N_EXT-1:0] ext_s1_r, ext_s2_r, ext_s3_r;
  reg [1:0] irq_stat_r, irq_mask_r;
  integer arb_i;
  integer flag_i;
  integer en_i;
  integer pri_i;
  integer rd_i;

  // ====================================================
  // Helpers
  // Word address of the register that holds a source's field
  function [4:0] word_addr;
    input [4:0] base;
    input integer idx;
    input integer per_word;
    integer w;
    begin
      w = idx / per_word;
      word_addr = base + w[4:0];
    end
  endfunction

  // Bit offset of a source's field inside its register
  function integer field_pos;
    input integer idx;
    input integer per_word;
    input integer stride;
    begin
      field_pos = (idx % per_word) * stride;
    end
  endfunction

  // ====================================================
  // Qualified strobes and levels
  wire wr_ok;
  wire rd_ok;
  wire [3:0] cpu_level;
  wire nest_dis;
  assign wr_ok = reg_wr & clk_en;
  assign rd_ok = reg_rd & clk_en;
  assign cpu_level = {cpu_priority_top_bit_r, cpu_priority_field_r}; //R10
  assign nest_dis = int_ctrl_one_r[`B_NEST_DIS]; //R16

  // ====================================================
  // Pin synchronisers and edge detect
  // Third stage only remembers the old level for the edge
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ext_s1_r <= {N_EXT{1'b0}};
      ext_s2_r <= {N_EXT{1'b0}};
      ext_s3_r <= {N_EXT{1'b0}};
    end else if (clk_en) begin
      ext_s1_r <= ext_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  wire [N_EXT-1:0] ext_rise;
  wire [N_EXT-1:0] ext_fall;
  wire [N_EXT-1:0] ext_edge;
  wire [N_SRC-1:0] hw_set;
  assign ext_rise = ext_s2_r & ~ext_s3_r;
  assign ext_fall = ~ext_s2_r & ext_s3_r;
  assign ext_edge = (ext_fall & ext_pol_r) | (ext_rise & ~ext_pol_r); //R17
  assign hw_set = periph_req | {{(N_SRC-N_EXT){1'b0}}, ext_edge}; //R1

  // ====================================================
  // Arbitration: strict greater wins, so ties go low
  reg found;
  reg [4:0] win;
  reg [2:0] best;
  always @* begin
    found = 1'b0;
    win = 5'h00;
    best = 3'h0;
    for (arb_i = 0; arb_i < N_SRC; arb_i = arb_i + 1) begin
      if (flag_r[arb_i] && en_r[arb_i] && pri_r[arb_i] != 3'h0 && //R2
          (!found || pri_r[arb_i] > best)) begin //R18
        found = 1'b1;
        win = arb_i[4:0];
        best = pri_r[arb_i];
      end
    end
  end

  wire blocked;
  wire take;
  wire [1:0] ev_now;
  wire stat_rd;
  assign blocked = cpu_priority_top_bit_r | //R11
    (cpu_priority_field_r == `LEVEL_BLOCK) |
    (nest_dis & in_service_r); //R16
  assign take = found && !blocked && ({1'b0, best} > cpu_level); //R18
  assign ev_now = {irq_ack & irq_pending, take & ~irq_pending};
  assign stat_rd = rd_ok && reg_addr == `A_IRQ_STAT;

  // ====================================================
  // Request flags: software clears, hardware set wins
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag_r <= {N_SRC{1'b0}};
    end else if (clk_en) begin
      for (flag_i = 0; flag_i < N_SRC; flag_i = flag_i + 1) begin
        if (hw_set[flag_i]) begin
          flag_r[flag_i] <= 1'b1; //R1
        end else if (wr_ok && reg_addr ==
            word_addr(`A_FLAG0, flag_i, `BITS_PER_WORD)) begin //R6
          flag_r[flag_i] <= reg_wdata[flag_i % `BITS_PER_WORD];
        end
      end
    end
  end

  // Enables
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      en_r <= {N_SRC{1'b0}};
    end else if (clk_en) begin
      for (en_i = 0; en_i < N_SRC; en_i = en_i + 1) begin
        if (wr_ok && reg_addr ==
            word_addr(`A_EN0, en_i, `BITS_PER_WORD)) begin //R6
          en_r[en_i] <= reg_wdata[en_i % `BITS_PER_WORD]; //R2
        end
      end
    end
  end

  // Priorities, three bits in each nibble
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (pri_i = 0; pri_i < N_SRC; pri_i = pri_i + 1) begin
        pri_r[pri_i] <= `PRI_RESET;
      end
    end else if (clk_en) begin
      for (pri_i = 0; pri_i < N_SRC; pri_i = pri_i + 1) begin
        if (wr_ok && reg_addr ==
            word_addr(`A_PRI0, pri_i, `PRI_PER_WORD)) begin //R6
          pri_r[pri_i] <= reg_wdata[field_pos(pri_i, `PRI_PER_WORD,
            `PRI_STRIDE) +: 3]; //R3
        end
      end
    end
  end

  // ====================================================
  // Control registers
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      int_ctrl_one_r <= 16'h0000;
      alt_table_select <= 1'b0;
      ext_pol_r <= {N_EXT{1'b0}};
      irq_mask_r <= 2'h0;
    end else if (wr_ok) begin
      case (reg_addr)
        `A_CTRL_ONE: begin
          int_ctrl_one_r <= reg_wdata; //R13
        end
        `A_CTRL_TWO: begin
          alt_table_select <= reg_wdata[`B_ALT_TABLE]; //R15
          ext_pol_r <= reg_wdata[N_EXT-1:0]; //R17
        end
        `A_IRQ_MASK: begin
          irq_mask_r <= reg_wdata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ====================================================
  // CPU priority level and service state
  // Top bit follows the trap line; software cannot write it
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_priority_top_bit_r <= 1'b0;
      cpu_priority_field_r <= 3'h0;
      in_service_r <= 1'b0;
    end else if (clk_en) begin
      cpu_priority_top_bit_r <= trap_active; //R9
      if (irq_ack && irq_pending) begin
        in_service_r <= 1'b1; //R16
        cpu_priority_field_r <= pending_new_level[2:0];
      end else begin
        if (wr_ok && reg_addr == `A_STATUS && !nest_dis) begin //R12
          cpu_priority_field_r <=
            reg_wdata[`F_CPU_PRI_HI:`F_CPU_PRI_LO]; //R8
        end
        if (irq_return) begin
          in_service_r <= 1'b0;
        end
      end
    end
  end

  // ====================================================
  // Presented interrupt: pending follows take, vector and level reload on every take, else held
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_pending <= 1'b0;
      pending_vector_number <= 7'h00;
      pending_new_level <= 4'h0;
    end else if (clk_en) begin
      irq_pending <= take;
      if (take) begin
        pending_vector_number <= `FIRST_VECTOR + {2'b00, win}; //R4 R7
        pending_new_level <= {1'b0, best}; //R5
      end
    end
  end

  // Events: bit 0 new presentation, bit 1 acknowledge; set beats clear
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= 2'h0;
    end else if (clk_en) begin
      if (stat_rd) begin
        irq_stat_r <= ev_now;
      end else begin
        irq_stat_r <= irq_stat_r | ev_now;
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ====================================================
  // Read data, one cycle after the strobe, else zero
  reg [15:0] rdata_nxt;
  always @* begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `A_CTRL_ONE: begin
          rdata_nxt = int_ctrl_one_r;
        end
        `A_CTRL_TWO: begin
          rdata_nxt[`B_ALT_TABLE] = alt_table_select;
          rdata_nxt[N_EXT-1:0] = ext_pol_r;
        end
        `A_PENDING: begin
          rdata_nxt[6:0] = pending_vector_number; //R4
          rdata_nxt[11:8] = pending_new_level;
        end
        `A_STATUS: begin
          rdata_nxt[`F_CPU_PRI_HI:`F_CPU_PRI_LO] = cpu_priority_field_r;
        end
        `A_CORE: begin
          rdata_nxt[`B_TOP_LEVEL] = cpu_priority_top_bit_r; //R9
        end
        `A_IRQ_STAT: begin
          rdata_nxt[1:0] = irq_stat_r;
        end
        `A_IRQ_MASK: begin
          rdata_nxt[1:0] = irq_mask_r;
        end
        `A_SERVICE: begin
          rdata_nxt[0] = in_service_r;
        end
        default: begin
          for (rd_i = 0; rd_i < N_SRC; rd_i = rd_i + 1) begin
            if (reg_addr == word_addr(`A_FLAG0, rd_i, `BITS_PER_WORD)) begin
              rdata_nxt[rd_i % `BITS_PER_WORD] = flag_r[rd_i];
            end
            if (reg_addr == word_addr(`A_EN0, rd_i, `BITS_PER_WORD)) begin
              rdata_nxt[rd_i % `BITS_PER_WORD] = en_r[rd_i];
            end
            if (reg_addr == word_addr(`A_PRI0, rd_i, `PRI_PER_WORD)) begin
              rdata_nxt[field_pos(rd_i, `PRI_PER_WORD, `PRI_STRIDE) +: 3] =
                pri_r[rd_i]; //R14
            end
          end
        end
      endcase
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= rdata_nxt;
    end
  end
endmodule // vpic_ctrl

/* vpic_ctrl_sva.sv */
// Port assertions for the interrupt controller
`include "vpic_defs.vh"
module vpic_ctrl_sva #(parameter N_SRC = 32, parameter N_EXT = 3) (
  input wire ref_clk,
  input wire rst,
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire trap_active,
  input wire irq_ack,
  input wire irq_pending,
  input wire [6:0] pending_vector_number,
  input wire [3:0] pending_new_level,
  input wire alt_table_select
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_RD_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  AST_UNMAPPED: assert property (
    $past(reg_rd && reg_addr > `A_SERVICE) |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_ALT_SET: assert property (reg_wr && reg_addr == `A_CTRL_TWO &&
    reg_wdata[15] |-> ##[1:2] alt_table_select) else $error("alt not set");
  AST_ALT_HOLD: assert property (
    !$past(reg_wr && reg_addr == `A_CTRL_TWO) &&
    !$past(reg_wr && reg_addr == `A_CTRL_TWO, 2) |->
    $stable(alt_table_select))
    else $error("alt changed without write");
  AST_TRAP: assert property ($past(trap_active) && $past(trap_active, 2) |->
    !irq_pending) else $error("user interrupt during trap");
  AST_VEC: assert property (irq_pending |-> pending_vector_number >=
    `FIRST_VECTOR && pending_vector_number < `FIRST_VECTOR + N_SRC)
    else $error("vector out of range");
  AST_LVL: assert property (irq_pending |->
    pending_new_level inside {[4'h1:4'h7]}) else $error("bad new level");
  AST_ACK: assert property (irq_ack && irq_pending |-> ##2 (!irq_pending ||
    pending_new_level > $past(pending_new_level, 2)))
    else $error("taken level not raised");
endmodule // vpic_ctrl_sva
bind vpic_ctrl vpic_ctrl_sva #(.N_SRC(N_SRC), .N_EXT(N_EXT)) vpic_ctrl_sva_i (
  .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .trap_active, .irq_ack, .irq_pending, .pending_vector_number,
  .pending_new_level, .alt_table_select);

/* vpic_cpu_model.sv */
// Behavioural processor core that takes presented interrupts
module vpic_cpu_model #(
  parameter int TAKE_DLY = 3,
  parameter int RET_DLY = 20
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cpu_en,
  input wire logic irq_pending,
  output logic irq_ack,
  output logic irq_return
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_r;
  int srv_r;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      wait_r <= 0;
      srv_r <= 0;
    end else begin
      irq_ack <= 1'b0;
      irq_return <= (srv_r == 1);
      if (srv_r > 0) srv_r <= srv_r - 1;
      // Slow take, so a stale presentation is not acknowledged
      wait_r <= (cpu_en && irq_pending && !irq_ack) ? wait_r + 1 : 0;
      if (wait_r == TAKE_DLY) begin
        irq_ack <= 1'b1;
        wait_r <= 0;
        srv_r <= RET_DLY;
      end
    end
  end
endmodule // vpic_cpu_model

/* vpic_ctrl_tb.sv */
// Testbench for the vectored priority interrupt controller
`include "vpic_defs.vh"
module vpic_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, trap_active = 0;
  logic cpu_en = 0, irq_ack, irq_return, irq_pending, alt_table_select, irq;
  logic [4:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata;
  logic [31:0] periph_req = 0;
  logic [2:0] ext_pin = 0;
  logic [6:0] pending_vector_number;
  logic [3:0] pending_new_level;
  int mismatches = 0, checks = 0;
  vpic_ctrl vpic_ctrl_i (.ref_clk, .rst, .clk_en(1'b1), .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .periph_req, .ext_pin, .trap_active,
    .irq_ack, .irq_return, .irq_pending, .pending_vector_number,
    .pending_new_level, .alt_table_select, .irq);
  vpic_cpu_model vpic_cpu_model_i (.ref_clk, .rst, .cpu_en, .irq_pending,
    .irq_ack, .irq_return);
  // ===========
  // Bus helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    // One idle edge, so a following write always re-raises the strobe
    tick(1);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    check(reg_rdata, exp);
    tick(1);
  endtask
  // =========
  // Scenarios
  task automatic t_reset();
    rd(`A_PRI0, 16'h4444);
    rd(5'h1f, 16'h0000);
  endtask
  task automatic t_flags();
    periph_req <= 32'h1;
    tick(1);
    periph_req <= 32'h0;
    rd(`A_FLAG0, 16'h0001);
    check(16'(irq_pending), 16'h0000);
    wr(`A_EN0, 16'h0001);
    tick(2);
    rd(`A_PENDING, 16'h0408);
    wr(`A_FLAG0, 16'h0000);
    ext_pin <= 3'h1;
    tick(5);
    rd(`A_FLAG0, 16'h0001);
    wr(`A_FLAG0, 16'h0000);
    wr(`A_CTRL_TWO, 16'h0001);
    ext_pin <= 3'h0;
    tick(5);
    rd(`A_FLAG0, 16'h0001);
    wr(`A_FLAG0, 16'h0000);
    rd(`A_FLAG0, 16'h0000);
  endtask
  task automatic t_arb();
    wr(`A_EN0, 16'h002a);
    wr(`A_PRI0, 16'h6064);
    periph_req <= 32'h2a;
    tick(1);
    periph_req <= 32'h0;
    tick(2);
    rd(`A_PENDING, 16'h0609);
    wr(`A_PRI0 + 5'h01, 16'h4474);
    tick(2);
    rd(`A_PENDING, 16'h070d);
  endtask
  task automatic t_block();
    wr(`A_STATUS, 16'h00e0);
    rd(`A_STATUS, 16'h00e0);
    check(16'(irq_pending), 16'h0000);
    wr(`A_STATUS, 16'h0000);
    trap_active <= 1'b1;
    tick(3);
    check(16'(irq_pending), 16'h0000);
    wr(`A_CORE, 16'h0000);
    rd(`A_CORE, 16'h0008);
    trap_active <= 1'b0;
    wr(`A_CTRL_ONE, 16'h8000);
    wr(`A_STATUS, 16'h00e0);
    rd(`A_STATUS, 16'h0000);
    wr(`A_CTRL_ONE, 16'h0000);
  endtask
  task automatic t_ack();
    wr(`A_IRQ_MASK, 16'h0002);
    tick(1);
    check(16'(irq), 16'h0000);
    cpu_en <= 1'b1;
    tick(8);
    check(16'(irq), 16'h0001);
    rd(`A_IRQ_STAT, 16'h0003);
    check(16'(irq), 16'h0000);
    rd(`A_STATUS, 16'h00e0);
    wr(`A_CTRL_TWO, 16'h8001);
    tick(2);
    check(16'(alt_table_select), 16'h0001);
  endtask
  task automatic t_nest();
    tick(20);
    rd(`A_SERVICE, 16'h0000);
    wr(`A_FLAG0, 16'h0000);
    wr(`A_PRI0 + 5'h01, 16'h4414);
    wr(`A_STATUS, 16'h0000);
    wr(`A_CTRL_ONE, 16'h8000);
    periph_req <= 32'h20;
    tick(1);
    periph_req <= 32'h0;
    tick(8);
    rd(`A_SERVICE, 16'h0001);
    periph_req <= 32'h2;
    tick(1);
    periph_req <= 32'h0;
    tick(3);
    check(16'(irq_pending), 16'h0000);
    check(16'(pending_vector_number), 16'h000d);
    tick(16);
    check(16'(irq_pending), 16'h0001);
    check(16'(pending_new_level), 16'h0006);
    check(16'(pending_vector_number), 16'h0009);
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // Tests need some hundred and sixty cycles; fifteen times that means a hang
  initial begin
    #20us;
    mismatches++;
    end_of_test();
  end
  initial begin
    tick(10);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_flags();
    t_arb();
    t_block();
    t_ack();
    t_nest();
    end_of_test();
  end
endmodule // vpic_ctrl_tb
